// ==== rtl/tbe_pkg.sv ====
// package: constants, states and state record of the trap and breakpoint exception unit
package tbe_pkg;

	// =====================================================================
	// opcode decode
	localparam logic [11:0] TRAP_OP_HI   = 12'h4E4;  // trap #n, n in low nibble
	localparam logic [15:0] SWB_OP_FIRST = 16'h4848; // first breakpoint opcode
	localparam logic [15:0] SWB_OP_LAST  = 16'h484F; // last breakpoint opcode

	// =====================================================================
	// vectors
	localparam logic [3:0] TRAP_VEC_HI = 4'h2;  // trap vectors start at 32
	localparam logic [7:0] VEC_ILLEGAL = 8'h04; // illegal instruction
	localparam logic [7:0] VEC_HWBKPT  = 8'h0C; // hardware breakpoint, offset 0x30
	localparam logic [7:0] VEC_FMTERR  = 8'h0E; // format error

	// =====================================================================
	// stack frame formats
	localparam logic [3:0] FMT_FOUR  = 4'h0; // four-word frame
	localparam logic [3:0] FMT_SIX   = 4'h2; // six-word frame with instruction address
	localparam logic [3:0] FMT_BUSER = 4'hC; // bus-fault frame, carries a version number

	// =====================================================================
	// cpu space acknowledge cycles
	localparam logic [2:0]  FC_CPU_SPACE = 3'h7;         // function code of cpu space
	localparam logic [31:0] HWB_ACK_ADDR = 32'h0000001E; // hardware breakpoint acknowledge
	localparam logic [4:0]  SWB_ADDR_LSB = 5'h02;        // breakpoint number sits at bit 2

	// =====================================================================
	// control states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SWB  = 4'h2,
		ST_HWB  = 4'h4,
		ST_REL  = 4'h8
	} tbe_st_t;

	// whole state of the unit
	typedef struct packed {
		tbe_st_t     st;
		logic        pend;
		logic [31:0] cur_pc;
		logic [31:0] nxt_pc;
		logic [15:0] sr;
		logic        bus_req;
		logic [31:0] bus_addr;
		logic        exc_valid;
		logic [7:0]  exc_vec;
		logic [31:0] exc_vaddr;
		logic [3:0]  exc_fmt;
		logic [31:0] exc_pc;
		logic [31:0] exc_iaddr;
		logic [15:0] exc_sr;
		logic        resume;
		logic        op_valid;
		logic [15:0] op;
	} tbe_state_t;

endpackage

// ==== rtl/tbe_sync.sv ====
// two-stage synchroniser for pin inputs of the exception unit
`timescale 1ns/1ps
`default_nettype none

module tbe_sync #(
	parameter int WIDTH  = 3,
	parameter int STAGES = 2
) (
	// clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             sys_rst_i,
	// asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	// =====================================================================
	// elaboration check
	if (WIDTH < 1 || STAGES < 2)
	begin : g_bad
		$error("tbe_sync needs WIDTH >= 1 and STAGES >= 2");
	end

	logic [WIDTH-1:0] stage_r [STAGES];

	// only the next stage reads each flop but the last, never logic
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < STAGES; i++)
				stage_r[i] <= '0;
		end
		else
		begin
			stage_r[0] <= async_i;
			for (int i = 1; i < STAGES; i++)
				stage_r[i] <= stage_r[i-1];
		end
	end

	assign sync_o = stage_r[STAGES-1];

endmodule // tbe_sync

`default_nettype wire

// ==== rtl/tbe_unit.sv ====
// trap, breakpoint and format error exception unit of the core
`timescale 1ns/1ps
`default_nettype none

module tbe_unit #(
	parameter logic [3:0] CPU_VERSION = 4'h1 // arbitrary version number of this core
) (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	// instruction stream from the core
	input  wire logic        exec_i,
	input  wire logic [15:0] opcode_i,
	input  wire logic [31:0] cur_pc_i,
	input  wire logic [31:0] next_pc_i,
	input  wire logic [15:0] status_register_i,
	input  wire logic [31:0] vector_base_register_i,
	input  wire logic        itrap_i,
	input  wire logic [7:0]  itrap_vec_i,
	input  wire logic        ins_done_i,
	input  wire logic        ins_bkpt_i,
	input  wire logic        boundary_i,
	// return from exception frame check
	input  wire logic        return_from_exception_i,
	input  wire logic [3:0]  frame_fmt_i,
	input  wire logic [3:0]  frame_ver_i,
	// answers to the core
	output logic             busy_o,
	output logic             exc_valid_o,
	output logic [7:0]       exc_vec_o,
	output logic [31:0]      exc_vaddr_o,
	output logic [3:0]       exc_fmt_o,
	output logic [31:0]      exc_pc_o,
	output logic [31:0]      exc_iaddr_o,
	output logic [15:0]      exc_sr_o,
	output logic             resume_o,
	output logic             bkpt_op_valid_o,
	output logic [15:0]      bkpt_op_o,
	// system bus, cpu space cycles
	input  wire logic        hw_bkpt_req_i,
	input  wire logic        data_size_acknowledge_i,
	input  wire logic        bus_error_input_i,
	input  wire logic [15:0] bus_data_i,
	output logic             bus_req_o,
	output logic [2:0]       bus_fc_o,
	output logic [31:0]      bus_addr_o
);

	// =====================================================================
	// helpers
	function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] vec);
		vec_addr = base + {22'h0, vec, 2'h0};
	endfunction

	function automatic logic is_swb(input logic [15:0] op);
		is_swb = (op >= tbe_pkg::SWB_OP_FIRST) && (op <= tbe_pkg::SWB_OP_LAST);
	endfunction

	// =====================================================================
	// pin synchronisers
	logic [2:0] pin_s;
	logic       hwreq_s;
	logic       ack_s;
	logic       bus_error_input_s;

	tbe_sync #(
		.WIDTH  (3),
		.STAGES (2)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({hw_bkpt_req_i, data_size_acknowledge_i, bus_error_input_i}),
		.sync_o    (pin_s)
	);

	assign hwreq_s = pin_s[2];
	assign ack_s   = pin_s[1];
	assign bus_error_input_s  = pin_s[0];

	// =====================================================================
	// next state
	tbe_pkg::tbe_state_t s_r;
	tbe_pkg::tbe_state_t s_nxt;
	logic                idle;
	logic                fmt_bad;
	logic                is_trap;

	assign idle    = (s_r.st == tbe_pkg::ST_IDLE);
	assign is_trap = exec_i && (opcode_i[15:4] == tbe_pkg::TRAP_OP_HI);
	assign fmt_bad = !((frame_fmt_i == tbe_pkg::FMT_FOUR) || (frame_fmt_i == tbe_pkg::FMT_SIX)
		|| ((frame_fmt_i == tbe_pkg::FMT_BUSER) && (frame_ver_i == CPU_VERSION)));

	always_comb
	begin
		s_nxt           = s_r;
		s_nxt.exc_valid = 1'b0;
		s_nxt.resume    = 1'b0;
		s_nxt.op_valid  = 1'b0;
		// cleared only when the acknowledge read starts; set wins
		if (idle && s_r.pend && boundary_i && !return_from_exception_i && !is_trap && !itrap_i
			&& !(exec_i && is_swb(opcode_i)))
			s_nxt.pend = 1'b0;
		if (hwreq_s || (ins_done_i && ins_bkpt_i))
			s_nxt.pend = 1'b1;
		unique case (s_r.st)
			tbe_pkg::ST_IDLE:
			begin
				s_nxt.cur_pc = cur_pc_i;
				s_nxt.nxt_pc = next_pc_i;
				s_nxt.sr     = status_register_i;
				if (return_from_exception_i)
				begin
					if (fmt_bad)
					begin
						s_nxt.exc_valid = 1'b1;
						s_nxt.exc_vec   = tbe_pkg::VEC_FMTERR;
						s_nxt.exc_vaddr = vec_addr(vector_base_register_i, tbe_pkg::VEC_FMTERR);
						s_nxt.exc_fmt   = tbe_pkg::FMT_FOUR;
						s_nxt.exc_pc    = cur_pc_i;
						s_nxt.exc_iaddr = cur_pc_i;
						s_nxt.exc_sr    = status_register_i;
					end
				end
				else if (is_trap)
				begin
					// trap vector from opcode, following address
					s_nxt.exc_valid = 1'b1;
					s_nxt.exc_vec   = {tbe_pkg::TRAP_VEC_HI, opcode_i[3:0]};
					s_nxt.exc_vaddr = vec_addr(vector_base_register_i,
						{tbe_pkg::TRAP_VEC_HI, opcode_i[3:0]});
					s_nxt.exc_fmt   = tbe_pkg::FMT_FOUR;
					s_nxt.exc_pc    = next_pc_i;
					s_nxt.exc_iaddr = cur_pc_i;
					s_nxt.exc_sr    = status_register_i;
				end
				else if (itrap_i)
				begin
					s_nxt.exc_valid = 1'b1;
					s_nxt.exc_vec   = itrap_vec_i;
					s_nxt.exc_vaddr = vec_addr(vector_base_register_i, itrap_vec_i);
					s_nxt.exc_fmt   = tbe_pkg::FMT_SIX;
					s_nxt.exc_pc    = next_pc_i;
					s_nxt.exc_iaddr = cur_pc_i;
					s_nxt.exc_sr    = status_register_i;
				end
				else if (exec_i && is_swb(opcode_i))
				begin
					s_nxt.st       = tbe_pkg::ST_SWB;
					s_nxt.bus_req  = 1'b1;
					s_nxt.bus_addr = {27'h0, opcode_i[2:0], 2'h0};
				end
				else if (s_r.pend && boundary_i)
				begin
					s_nxt.st       = tbe_pkg::ST_HWB;
					s_nxt.bus_req  = 1'b1;
					s_nxt.bus_addr = tbe_pkg::HWB_ACK_ADDR;
				end
			end
			tbe_pkg::ST_SWB:
			begin
				if (bus_error_input_s)
				begin
					s_nxt.st        = tbe_pkg::ST_REL;
					s_nxt.bus_req   = 1'b0;
					s_nxt.exc_valid = 1'b1;
					s_nxt.exc_vec   = tbe_pkg::VEC_ILLEGAL;
					s_nxt.exc_vaddr = vec_addr(vector_base_register_i, tbe_pkg::VEC_ILLEGAL);
					s_nxt.exc_fmt   = tbe_pkg::FMT_FOUR;
					s_nxt.exc_pc    = s_r.cur_pc;
					s_nxt.exc_iaddr = s_r.cur_pc;
					s_nxt.exc_sr    = s_r.sr;
				end
				else if (ack_s)
				begin
					s_nxt.st       = tbe_pkg::ST_REL;
					s_nxt.bus_req  = 1'b0;
					s_nxt.op_valid = 1'b1;
					s_nxt.op       = bus_data_i;
				end
			end
			tbe_pkg::ST_HWB:
			begin
				if (bus_error_input_s)
				begin
					s_nxt.st        = tbe_pkg::ST_REL;
					s_nxt.bus_req   = 1'b0;
					s_nxt.exc_valid = 1'b1;
					s_nxt.exc_vec   = tbe_pkg::VEC_HWBKPT;
					s_nxt.exc_vaddr = vec_addr(vector_base_register_i, tbe_pkg::VEC_HWBKPT);
					s_nxt.exc_fmt   = tbe_pkg::FMT_SIX;
					s_nxt.exc_pc    = s_r.nxt_pc;
					s_nxt.exc_iaddr = s_r.cur_pc;
					s_nxt.exc_sr    = s_r.sr;
				end
				else if (ack_s)
				begin
					s_nxt.st      = tbe_pkg::ST_REL;
					s_nxt.bus_req = 1'b0;
					s_nxt.resume  = 1'b1;
				end
			end
			tbe_pkg::ST_REL:
			begin
				// wait for both terminations to drop so the next cycle is not ended early
				if (!ack_s && !bus_error_input_s)
					s_nxt.st = tbe_pkg::ST_IDLE;
			end
			default:
				s_nxt.st = tbe_pkg::ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			s_r    <= '0;
			s_r.st <= tbe_pkg::ST_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	// =====================================================================
	// outputs
	assign busy_o          = !idle;
	assign exc_valid_o     = s_r.exc_valid;
	assign exc_vec_o       = s_r.exc_vec;
	assign exc_vaddr_o     = s_r.exc_vaddr;
	assign exc_fmt_o       = s_r.exc_fmt;
	assign exc_pc_o        = s_r.exc_pc;
	assign exc_iaddr_o     = s_r.exc_iaddr;
	assign exc_sr_o        = s_r.exc_sr;
	assign resume_o        = s_r.resume;
	assign bkpt_op_valid_o = s_r.op_valid;
	assign bkpt_op_o       = s_r.op;
	assign bus_req_o       = s_r.bus_req;
	assign bus_fc_o        = tbe_pkg::FC_CPU_SPACE;
	assign bus_addr_o      = s_r.bus_addr;

	// =====================================================================
	// assertions
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_trap_vec;
		idle && !return_from_exception_i && is_trap
			|=> exc_valid_o && exc_vec_o == {4'h2, $past(opcode_i[3:0])};
	endproperty
	a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");

	property p_trap_pc;
		idle && !return_from_exception_i && is_trap |=> exc_pc_o == $past(next_pc_i);
	endproperty
	a_trap_pc: assert property (p_trap_pc) else $error("trap stacked pc wrong");

	property p_itrap;
		idle && !return_from_exception_i && !is_trap && itrap_i
			|=> exc_fmt_o == 4'h2 && exc_iaddr_o == $past(cur_pc_i);
	endproperty
	a_itrap: assert property (p_itrap) else $error("instruction trap frame wrong");

	property p_swb_read;
		idle && !return_from_exception_i && !itrap_i && exec_i
			&& opcode_i[15:3] == 13'h0909
			|=> bus_req_o && bus_fc_o == 3'h7 && bus_addr_o == {27'h0, $past(opcode_i[2:0]), 2'h0};
	endproperty
	a_swb_read: assert property (p_swb_read) else $error("breakpoint read wrong");

	property p_swb_bus_error_input;
		s_r.st == tbe_pkg::ST_SWB && bus_error_input_s |=> exc_valid_o && exc_vec_o == 8'h04 && !bus_req_o;
	endproperty
	a_swb_bus_error_input: assert property (p_swb_bus_error_input) else $error("illegal exception missing");

	property p_swb_ack;
		s_r.st == tbe_pkg::ST_SWB && ack_s && !bus_error_input_s
			|=> bkpt_op_valid_o && bkpt_op_o == $past(bus_data_i) && !exc_valid_o;
	endproperty
	a_swb_ack: assert property (p_swb_ack) else $error("replacement opcode wrong");

	property p_pend;
		ins_done_i && ins_bkpt_i |=> s_r.pend;
	endproperty
	a_pend: assert property (p_pend) else $error("breakpoint not pending");

	property p_hw_ack;
		s_r.st == tbe_pkg::ST_HWB |-> bus_req_o && bus_addr_o == 32'h0000001E && !exc_valid_o;
	endproperty
	a_hw_ack: assert property (p_hw_ack) else $error("acknowledge read wrong");

	property p_hw_ok;
		s_r.st == tbe_pkg::ST_HWB && ack_s && !bus_error_input_s |=> resume_o && !exc_valid_o;
	endproperty
	a_hw_ok: assert property (p_hw_ok) else $error("resume missing");

	property p_hw_bus_error_input;
		s_r.st == tbe_pkg::ST_HWB && bus_error_input_s
			|=> exc_valid_o && exc_vec_o == 8'h0C && !bkpt_op_valid_o
			&& exc_vaddr_o == $past(vector_base_register_i) + 32'h30
			&& exc_pc_o == $past(s_r.nxt_pc) && exc_iaddr_o == $past(s_r.cur_pc);
	endproperty
	a_hw_bus_error_input: assert property (p_hw_bus_error_input) else $error("breakpoint exception wrong");

	property p_fmt;
		idle && return_from_exception_i && fmt_bad
			|=> exc_valid_o && exc_vec_o == 8'h0E && exc_fmt_o == 4'h0
			&& exc_vaddr_o == $past(vector_base_register_i) + 32'h38;
	endproperty
	a_fmt: assert property (p_fmt) else $error("format error wrong");

endmodule // tbe_unit

`default_nettype wire

// ==== sim/tbe_bus_model.sv ====
// far-side logic that terminates cpu space reads of the exception unit
`timescale 1ns/1ps
`default_nettype none

module tbe_bus_model (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	// cpu space read from the unit
	input  wire logic        bus_req_i,
	// answer chosen by the bench
	input  wire logic        bus_error_input_mode_i,
	input  wire logic [3:0]  delay_i,
	input  wire logic [15:0] word_i,
	// termination pins and read data
	output logic             ack_o,
	output logic             bus_error_input_o,
	output logic [15:0]      data_o
);
	// =====================================================================
	// termination
	logic [3:0] wait_r;

	// answers after a chosen delay; released data shows its inverse so a stale word never passes
	// error or instruction word
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			{ack_o, bus_error_input_o, wait_r} <= '0;
			data_o <= 16'hA5A5;
		end
		else if (bus_req_i && !(ack_o || bus_error_input_o))
		begin
			if (wait_r >= delay_i)
			begin
				ack_o  <= !bus_error_input_mode_i;
				bus_error_input_o <= bus_error_input_mode_i;
				data_o <= word_i;
			end
			else
				wait_r <= wait_r + 4'h1;
		end
		// pins drop only after the request has gone
		else if (!bus_req_i && (ack_o || bus_error_input_o))
		begin
			{ack_o, bus_error_input_o, wait_r} <= '0;
			data_o <= ~data_o;
		end
	end

endmodule // tbe_bus_model

`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench of the trap and breakpoint exception unit
`timescale 1ns/1ps
`default_nettype none

// one counted comparison, a mismatch printed at once
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end

module tb;
	// =====================================================================
	// signals
	logic        sys_clk_i, sys_rst_i, exec_i, itrap_i, ins_done_i, ins_bkpt_i, boundary_i;
	logic        return_from_exception_i, hw_bkpt_req_i, data_size_acknowledge_i;
	logic        bus_error_input_i, busy_o, exc_valid_o, resume_o, bkpt_op_valid_o, bus_req_o;
	logic        bus_error_input_mode;
	logic [15:0] opcode_i, status_register_i, bkpt_op_o, bus_data_i, exc_sr_o, word;
	logic [31:0] cur_pc_i, next_pc_i, vector_base_register_i, exc_vaddr_o, exc_pc_o;
	logic [31:0] exc_iaddr_o, bus_addr_o, seen_addr;
	logic [7:0]  itrap_vec_i, exc_vec_o, frm;
	logic [3:0]  frame_fmt_i, frame_ver_i, exc_fmt_o, dly;
	logic [2:0]  bus_fc_o, seen_fc;
	int          errors, check_count, seed, i;
	localparam logic [3:0] VER = 4'h1; // arbitrary version number
	localparam logic [7:0] FRAMES [8] = '{8'h01, 8'h23, 8'hC1, 8'hC2, 8'h51, 8'hF1, 8'hC0, 8'h1F};

	tbe_unit #(.CPU_VERSION(VER)) i_tbe_unit (
		.sys_clk_i, .sys_rst_i, .exec_i, .opcode_i, .cur_pc_i, .next_pc_i, .status_register_i,
		.vector_base_register_i, .itrap_i, .itrap_vec_i, .ins_done_i, .ins_bkpt_i, .boundary_i,
		.return_from_exception_i, .frame_fmt_i, .frame_ver_i, .busy_o, .exc_valid_o, .exc_vec_o,
		.exc_vaddr_o, .exc_fmt_o, .exc_pc_o, .exc_iaddr_o, .exc_sr_o, .resume_o, .bkpt_op_valid_o,
		.bkpt_op_o, .hw_bkpt_req_i, .data_size_acknowledge_i, .bus_error_input_i, .bus_data_i,
		.bus_req_o, .bus_fc_o, .bus_addr_o
	);
	tbe_bus_model i_tbe_bus_model (
		.sys_clk_i, .sys_rst_i, .bus_req_i(bus_req_o), .bus_error_input_mode_i(bus_error_input_mode), .delay_i(dly),
		.word_i(word), .ack_o(data_size_acknowledge_i), .bus_error_input_o(bus_error_input_i),
		.data_o(bus_data_i)
	);

	// clock, 10 ns
	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// what each cpu space cycle presents
	always @(posedge sys_clk_i)
		if (bus_req_o === 1'b1)
		begin
			seen_addr <= bus_addr_o;
			seen_fc <= bus_fc_o;
		end

	// =====================================================================
	// expectations and drivers
	function automatic logic [31:0] vadr(input logic [7:0] v);
		return vector_base_register_i + {22'h0, v, 2'b00};
	endfunction

	function automatic logic frame_bad(input logic [7:0] fv);
		return !(fv[7:4] == tbe_pkg::FMT_FOUR || fv[7:4] == tbe_pkg::FMT_SIX ||
			(fv[7:4] == tbe_pkg::FMT_BUSER && fv[3:0] == VER));
	endfunction

	// one event for one cycle, only once the unit is idle, with fresh random context
	task automatic go(input logic [5:0] e, input logic [15:0] op, input logic [7:0] ax);
		int k;
		for (k = 0; k < 50 && busy_o !== 1'b0; k++)
		begin
			@(posedge sys_clk_i);
			#1;
		end
		// a unit that never goes idle counts as a mismatch
		if (busy_o !== 1'b0)
			errors++;
		@(posedge sys_clk_i);
		{return_from_exception_i, boundary_i, ins_bkpt_i, ins_done_i, itrap_i, exec_i} <= e;
		opcode_i <= op;
		itrap_vec_i <= ax;
		{frame_fmt_i, frame_ver_i} <= ax;
		cur_pc_i <= $random(seed);
		next_pc_i <= $random(seed);
		status_register_i <= 16'($random(seed));
		vector_base_register_i <= $random(seed);
		@(posedge sys_clk_i);
		{return_from_exception_i, boundary_i, ins_bkpt_i, ins_done_i, itrap_i, exec_i} <= 6'h00;
		#1;
	endtask

	// bounded wait for any answer pulse
	task automatic wait_out();
		int k;
		for (k = 0; k < 40 && !(exc_valid_o | resume_o | bkpt_op_valid_o); k++)
		begin
			@(posedge sys_clk_i);
			#1;
		end
	endtask

	task automatic exp_exc(input logic [7:0] v, input logic [3:0] f, input logic [31:0] pc);
		wait_out();
		`CHK("exc valid", 1'b1, exc_valid_o)
		`CHK("vector", v, exc_vec_o)
		`CHK("vector address", vadr(v), exc_vaddr_o)
		`CHK("frame format", f, exc_fmt_o)
		`CHK("stacked pc", pc, exc_pc_o)
		`CHK("stacked sr", status_register_i, exc_sr_o)
		if (f === tbe_pkg::FMT_SIX)
			`CHK("instruction address", cur_pc_i, exc_iaddr_o)
	endtask

	task automatic exp_none();
		wait_out();
		`CHK("no answer", 1'b0, exc_valid_o | resume_o | bkpt_op_valid_o | bus_req_o | busy_o)
	endtask

	task automatic results();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// hang guard, far beyond the expected run
	initial
	begin
		#300000;
		errors++;
		results();
	end

	// =====================================================================
	// main sequence
	initial
	begin
		seed = 32'h1C60208B;
		{errors, check_count} = '0;
		sys_rst_i = 1'b1;
		{exec_i, itrap_i, ins_done_i, ins_bkpt_i, boundary_i, return_from_exception_i} = '0;
		{hw_bkpt_req_i, bus_error_input_mode, dly, word, opcode_i, itrap_vec_i, frame_fmt_i} = '0;
		{frame_ver_i, cur_pc_i, next_pc_i, status_register_i, vector_base_register_i} = '0;
		repeat (10) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		// every trap number
		for (i = 0; i < 16; i++)
		begin
			go(6'h01, {tbe_pkg::TRAP_OP_HI, 4'(i)}, 8'h00);
			exp_exc({tbe_pkg::TRAP_VEC_HI, 4'(i)}, tbe_pkg::FMT_FOUR, next_pc_i);
		end
		// other instruction traps
		for (i = 0; i < 4; i++)
		begin
			go(6'h02, 16'h0000, 8'($random(seed)));
			exp_exc(itrap_vec_i, tbe_pkg::FMT_SIX, next_pc_i);
		end
		// all eight breakpoint numbers, random delay, error on odd ones
		for (i = 0; i < 8; i++)
		begin
			bus_error_input_mode = i[0];
			dly = 4'($random(seed) & 7);
			word = 16'($random(seed));
			go(6'h01, tbe_pkg::SWB_OP_FIRST + 16'(i), 8'h00);
			`CHK("busy", 1'b1, busy_o)
			if (bus_error_input_mode)
				exp_exc(tbe_pkg::VEC_ILLEGAL, tbe_pkg::FMT_FOUR, cur_pc_i);
			else
			begin
				wait_out();
				`CHK("op valid", 1'b1, bkpt_op_valid_o)
				`CHK("replacement opcode", word, bkpt_op_o)
			end
			`CHK("breakpoint address", 32'(i) << tbe_pkg::SWB_ADDR_LSB, seen_addr)
			`CHK("address space", tbe_pkg::FC_CPU_SPACE, seen_fc)
		end
		// neighbours of the breakpoint range
		go(6'h01, 16'h4847, 8'h00);
		exp_none();
		go(6'h01, 16'h4850, 8'h00);
		exp_none();
		// pin request pends, then normal and error acknowledge at a boundary
		for (i = 0; i < 2; i++)
		begin
			bus_error_input_mode = i[0];
			@(posedge sys_clk_i);
			hw_bkpt_req_i <= 1'b1;
			@(posedge sys_clk_i);
			hw_bkpt_req_i <= 1'b0;
			exp_none();
			go(6'h10, 16'h0000, 8'h00);
			if (bus_error_input_mode)
			begin
				exp_exc(tbe_pkg::VEC_HWBKPT, tbe_pkg::FMT_SIX, next_pc_i);
				`CHK("data ignored", 1'b0, resume_o | bkpt_op_valid_o)
			end
			else
			begin
				wait_out();
				`CHK("resume", 2'b10, {resume_o, exc_valid_o})
			end
			`CHK("acknowledge address", tbe_pkg::HWB_ACK_ADDR, seen_addr)
		end
		// a tag pends only with a completed instruction
		bus_error_input_mode = 1'b0;
		go(6'h08, 16'h0000, 8'h00);
		go(6'h10, 16'h0000, 8'h00);
		exp_none();
		go(6'h0C, 16'h0000, 8'h00);
		go(6'h10, 16'h0000, 8'h00);
		wait_out();
		`CHK("tagged resume", 1'b1, resume_o)
		// frame checks, table then random
		for (i = 0; i < 12; i++)
		begin
			frm = (i < 8) ? FRAMES[i] : 8'($random(seed));
			go(6'h20, 16'h0000, frm);
			if (frame_bad(frm))
				exp_exc(tbe_pkg::VEC_FMTERR, tbe_pkg::FMT_FOUR, cur_pc_i);
			else
				exp_none();
		end
		results();
	end

endmodule // tb

`default_nettype wire
